// >>> rhd_pkg.sv
// package: offsets, field layout, reset values and timing for the root hub descriptor block
package rhd_pkg;

    // ========================================================================
    // register map
    // ========================================================================
    localparam logic [11:0] RHD_BAR_OFFSET  = 12'h010;   // config-space base address register
    localparam logic [11:0] RHD_DESC_A_OFFS = 12'h048;   // first descriptor, within memory space
    localparam logic [11:0] RHD_DESC_B_OFFS = 12'h04c;   // second descriptor, within memory space

    // ========================================================================
    // field positions of the first descriptor
    // ========================================================================
    localparam int RHD_POTPG_LSB  = 24;                  // power-good wait, bits 31..24
    localparam int RHD_RSVD_MSB   = 23;                  // reserved, bits 23..13
    localparam int RHD_RSVD_LSB   = 13;
    localparam int RHD_NOOC_BIT   = 12;                  // overcurrent protection absent
    localparam int RHD_OCMODE_BIT = 11;                  // overcurrent report mode
    localparam int RHD_COMP_BIT   = 10;                  // compound device flag
    localparam int RHD_NOPS_BIT   = 9;                   // power switching absent
    localparam int RHD_PSCOPE_BIT = 8;                   // power switching scope
    localparam int RHD_NDP_LSB    = 0;                   // downstream port count, bits 7..0

    // ========================================================================
    // reset values and limits
    // ========================================================================
    localparam logic [7:0]  RHD_POTPG_RST  = 8'h01;      // 1 unit of 2 ms
    localparam logic        RHD_NOOC_RST   = 1'b0;
    localparam logic        RHD_NOPS_RST   = 1'b0;
    localparam logic        RHD_PSCOPE_RST = 1'b1;       // per-port switching
    localparam logic [7:0]  RHD_NDP_RST    = 8'h02;
    localparam logic [7:0]  RHD_NDP_MIN    = 8'h01;
    localparam logic [7:0]  RHD_NDP_MAX    = 8'h0f;
    localparam logic [10:0] RHD_RSVD_RST   = 11'h000;
    localparam logic [31:0] RHD_DESC_B_RST = 32'h0000_0000;

    // ========================================================================
    // timing
    // ========================================================================
    localparam int RHD_CLK_NS     = 25;                  // 40 MHz system clock
    localparam int RHD_UNIT_MS    = 2;                   // power-good unit
    localparam int RHD_UNIT_CYC   = RHD_UNIT_MS * 1000000 / RHD_CLK_NS;
    localparam int RHD_MAX_PORTS  = 15;

    // ========================================================================
    // carriers
    // ========================================================================
    typedef struct packed {
        logic        rd;                                 // read strobe
        logic        wr;                                 // write strobe
        logic [11:0] addr;                               // byte offset in memory space
        logic [31:0] wdata;                              // write data
    } rhd_req_s;

    typedef struct packed {
        logic [7:0] potpg;
        logic       nooc;
        logic       ocmode;
        logic       nops;
        logic       pscope;
        logic [7:0] downstream_port_count;
    } rhd_desc_s;

endpackage : rhd_pkg

// >>> rhd_port_power.sv
// one downstream port power switch, global or per-port steered
`timescale 1ns/1ps
module rhd_port_power
    import rhd_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // mode
    input  wire logic nops,
    input  wire logic pscope,
    input  wire logic mask,
    // commands
    input  wire logic glob_set,
    input  wire logic glob_clr,
    input  wire logic port_set,
    input  wire logic port_clr,
    // state
    output logic      powered
);
    logic pwr_reg;                                       // port power state
    logic pwr_next;

    // ========================================================================
    // command steering
    // ========================================================================
    always_comb begin
        pwr_next = pwr_reg;
        if (nops) begin
            pwr_next = 1'b1;                             // always powered
        end else if (pscope && mask) begin
            if (port_set) pwr_next = 1'b1;               // [R10]
            else if (port_clr) pwr_next = 1'b0;          // [R10]
        end else begin
            if (glob_set) pwr_next = 1'b1;               // [R10]
            else if (glob_clr) pwr_next = 1'b0;          // [R10]
        end
    end

    // state register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) pwr_reg <= 1'b0;
        else pwr_reg <= pwr_next;
    end

    assign powered = pwr_reg;
endmodule : rhd_port_power

// >>> rhd_root_hub_desc.sv
// root hub descriptor registers with downstream port power switching
//
// Contract
// [R1] power-good wait byte in bits 31..24, 2 ms units
// [R2] software waits value times 2 ms before access
// [R3] software writes reserved bits 23..13 as reset
// [R4] bit 12 set means no overcurrent protection
// [R5] bit 11 picks collective or per-port overcurrent
// [R6] overcurrent mode resets equal to switching scope
// [R7] compound device flag always reads zero
// [R8] bit 9 set means ports always powered
// [R9] bit 8 picks ganged or per-port switching
// [R10] masked ports obey per-port commands, others global; code applies the mask only with bit 8 set, all ports global otherwise
// [R11] port count in bits 7..0, 1 to 15
// [R12] register readable at offset 48h of memory space
// [R13] second descriptor holds remaining hub characteristics
// [R14] writes to compound device flag are ignored
`timescale 1ns/1ps
module rhd_root_hub_desc
    import rhd_pkg::*;
#(
    parameter int NPORTS = 2                             // physical downstream ports
)(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // memory-space register access
    input  wire rhd_req_s          req,
    output logic                   rd_valid,
    output logic [31:0]            rd_data,
    // power commands from the port logic
    input  wire logic              glob_set,
    input  wire logic              glob_clr,
    input  wire logic [NPORTS-1:0] port_set,
    input  wire logic [NPORTS-1:0] port_clr,
    // power and overcurrent view
    output logic [NPORTS-1:0]      port_powered,
    output logic [NPORTS-1:0]      port_good,
    output logic                   oc_per_port,
    output logic                   oc_enabled
);

    // ========================================================================
    // state
    // ========================================================================
    typedef struct packed {
        rhd_desc_s         desc;                         // first descriptor fields
        logic [31:0]       desc_b;                       // second descriptor, software owned
        logic              rd_valid;
        logic [31:0]       rd_data;
        logic [NPORTS-1:0] powered;                      // registered port power
        logic [NPORTS-1:0] good;                         // power-good reached
        logic [NPORTS-1:0][7:0] units;                   // elapsed 2 ms units per port
        logic [31:0]       tick;                         // cycles inside current unit
        logic              oc_per_port;
        logic              oc_enabled;
    } rhd_state_s;

    rhd_state_s st_reg;                                  // registered state
    rhd_state_s st_next;                                 // next state
    logic [NPORTS-1:0] sw_pwr;                           // switch outputs
    logic [31:0]       word;                             // assembled read word
    logic [NPORTS-1:0] mask;                             // per-port power mask from desc_b

    assign mask = st_reg.desc_b[16 +: NPORTS];

    // ========================================================================
    // port power switches
    // ========================================================================
    for (genvar i = 0; i < NPORTS; i++) begin : g_port
        rhd_port_power u_pwr (
            .sys_clk  (sys_clk),
            .sys_rst  (sys_rst),
            .nops     (st_reg.desc.nops),                // [R8]
            .pscope   (st_reg.desc.pscope),              // [R9]
            .mask     (mask[i]),
            .glob_set (glob_set),
            .glob_clr (glob_clr),
            .port_set (port_set[i]),
            .port_clr (port_clr[i]),
            .powered  (sw_pwr[i])
        );
    end

    // ========================================================================
    // read word assembly
    // ========================================================================
    always_comb begin
        word = 32'h0000_0000;
        word[RHD_POTPG_LSB +: 8] = st_reg.desc.potpg;    // [R1]
        word[RHD_NOOC_BIT]       = st_reg.desc.nooc;     // [R4]
        word[RHD_OCMODE_BIT]     = st_reg.desc.ocmode;   // [R5]
        word[RHD_COMP_BIT]       = 1'b0;                 // [R7]
        word[RHD_NOPS_BIT]       = st_reg.desc.nops;     // [R8]
        word[RHD_PSCOPE_BIT]     = st_reg.desc.pscope;   // [R9]
        word[RHD_NDP_LSB +: 8]   = st_reg.desc.downstream_port_count;      // [R11]
    end

    // ========================================================================
    // next state
    // ========================================================================
    always_comb begin
        st_next          = st_reg;
        st_next.rd_valid = 1'b0;
        st_next.powered  = sw_pwr;
        // reads: one-cycle answer
        if (req.rd) begin
            st_next.rd_valid = 1'b1;
            if (req.addr == RHD_DESC_A_OFFS) st_next.rd_data = word;        // [R12]
            else if (req.addr == RHD_DESC_B_OFFS) st_next.rd_data = st_reg.desc_b; // [R13]
            else st_next.rd_data = 32'h0000_0000;        // unmapped reads zero
        end
        // writes: reserved and compound flag are not stored
        if (req.wr && req.addr == RHD_DESC_A_OFFS) begin
            st_next.desc.potpg  = req.wdata[RHD_POTPG_LSB +: 8];            // [R1]
            st_next.desc.nooc   = req.wdata[RHD_NOOC_BIT];                  // [R4]
            st_next.desc.ocmode = req.wdata[RHD_OCMODE_BIT];                // [R5]
            st_next.desc.nops   = req.wdata[RHD_NOPS_BIT];                  // [R8]
            st_next.desc.pscope = req.wdata[RHD_PSCOPE_BIT];                // [R9]
            // bit 10 dropped on purpose                                   // [R14]
            // port count clamped to RHD_NDP_MAX (15), not to NPORTS, never below 1
            if (req.wdata[7:0] < RHD_NDP_MIN) st_next.desc.downstream_port_count = RHD_NDP_MIN;  // [R11]
            else if (req.wdata[7:0] > RHD_NDP_MAX) st_next.desc.downstream_port_count = RHD_NDP_MAX; // [R11]
            else st_next.desc.downstream_port_count = req.wdata[7:0];
        end
        if (req.wr && req.addr == RHD_DESC_B_OFFS) begin
            st_next.desc_b = req.wdata;                  // [R13]
        end
        // overcurrent view only meaningful with protection present
        st_next.oc_enabled  = ~st_reg.desc.nooc;         // [R4]
        st_next.oc_per_port = ~st_reg.desc.nooc & st_reg.desc.ocmode; // [R5]
        // power-good timing: one 2 ms tick shared by all ports
        if (st_reg.tick == 32'(RHD_UNIT_CYC - 1)) st_next.tick = 32'h0000_0000;
        else st_next.tick = st_reg.tick + 32'h0000_0001;
        for (int p = 0; p < NPORTS; p++) begin
            if (!sw_pwr[p]) begin
                // cleared with the switch, so good never outlives power
                st_next.units[p] = 8'h00;
                st_next.good[p]  = 1'b0;
            end else if (st_reg.units[p] >= st_reg.desc.potpg) begin
                st_next.good[p] = 1'b1;                  // [R2] wait elapsed
            end else if (st_reg.tick == 32'(RHD_UNIT_CYC - 1)) begin
                st_next.units[p] = st_reg.units[p] + 8'h01;  // [R1]
            end
        end
    end

    // ========================================================================
    // state register
    // ========================================================================
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_reg             <= '0;
            st_reg.desc.potpg  <= RHD_POTPG_RST;
            st_reg.desc.nooc   <= RHD_NOOC_RST;
            st_reg.desc.ocmode <= RHD_PSCOPE_RST;        // [R6]
            st_reg.desc.nops   <= RHD_NOPS_RST;
            st_reg.desc.pscope <= RHD_PSCOPE_RST;
            st_reg.desc.downstream_port_count    <= RHD_NDP_RST;
            st_reg.desc_b      <= RHD_DESC_B_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flip-flops
    assign rd_valid     = st_reg.rd_valid;
    assign rd_data      = st_reg.rd_data;
    assign port_powered = st_reg.powered;
    assign port_good    = st_reg.good;
    assign oc_per_port  = st_reg.oc_per_port;
    assign oc_enabled   = st_reg.oc_enabled;

endmodule : rhd_root_hub_desc

// >>> rhd_root_hub_desc_chk.sv
// checker: port-level assertions for the root hub descriptor block
`timescale 1ns/1ps
module rhd_chk
    import rhd_pkg::*;
#(
    parameter int NPORTS = 2
)(
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    // register access
    input wire rhd_req_s          req,
    input wire logic              rd_valid,
    input wire logic [31:0]       rd_data,
    // power commands and view
    input wire logic              glob_set,
    input wire logic              glob_clr,
    input wire logic [NPORTS-1:0] port_set,
    input wire logic [NPORTS-1:0] port_clr,
    input wire logic [NPORTS-1:0] port_powered,
    input wire logic [NPORTS-1:0] port_good,
    input wire logic              oc_per_port,
    input wire logic              oc_enabled
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ========================================================================
    // helpers
    // ========================================================================
    logic [11:0] addr_reg;   // address of the read being answered
    logic        a_rd;       // answer cycle of a first-descriptor read
    always_ff @(posedge sys_clk) begin
        addr_reg <= req.addr;
    end
    assign a_rd = rd_valid && (addr_reg == RHD_DESC_A_OFFS);
    // ========================================================================
    // assertions
    // ========================================================================
    property p_rd_lat; req.rd |=> rd_valid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read not answered");
    property p_rd_src; rd_valid |-> $past(req.rd); endproperty
    a_rd_src: assert property (p_rd_src) else $error("stray read answer");
    property p_comp; a_rd |-> !rd_data[RHD_COMP_BIT]; endproperty
    a_comp: assert property (p_comp) else $error("compound flag set");
    property p_ndp; a_rd |-> rd_data[7:0] inside {[8'h01:8'h0f]}; endproperty
    a_ndp: assert property (p_ndp) else $error("port count out of range");
    // oc outputs lag a write by a couple of cycles, so quiet writes first
    property p_oc;
        a_rd && !$past(req.wr) && !$past(req.wr, 2) && !$past(sys_rst, 2)
            && !$past(sys_rst, 3) |-> oc_enabled == !rd_data[12]
            && oc_per_port == (!rd_data[12] && rd_data[11]);
    endproperty
    a_oc: assert property (p_oc) else $error("overcurrent view wrong");
    property p_nops; a_rd && rd_data[9] |-> ##[0:4] (&port_powered); endproperty
    a_nops: assert property (p_nops) else $error("ports not forced on");
    property p_good; (port_good & ~port_powered) == '0; endproperty
    a_good: assert property (p_good) else $error("good without power");
    property p_quiet;
        (!glob_set && !glob_clr && port_set == '0 && port_clr == '0 && !req.wr) [*3]
            |=> $stable(port_powered);
    endproperty
    a_quiet: assert property (p_quiet) else $error("power moved by itself");
endmodule : rhd_chk

bind rhd_root_hub_desc rhd_chk #(.NPORTS(NPORTS)) u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .rd_valid(rd_valid),
    .rd_data(rd_data), .glob_set(glob_set), .glob_clr(glob_clr),
    .port_set(port_set), .port_clr(port_clr), .port_powered(port_powered),
    .port_good(port_good), .oc_per_port(oc_per_port), .oc_enabled(oc_enabled)
);

// >>> tb_rhd_root_hub_desc.sv
// testbench: self-checking bench for the root hub descriptor block
`timescale 1ns/1ps
module tb_rhd_root_hub_desc;
    import rhd_pkg::*;
    typedef struct packed { logic [31:0] wd; logic [31:0] exp; } rhd_row_s;
    // ========================================================================
    // signals
    // ========================================================================
    logic        sys_clk = 1'b0;
    logic        sys_rst;
    rhd_req_s    req;
    logic        rd_valid, glob_set, glob_clr, oc_per_port, oc_enabled;
    logic [31:0] rd_data, rdat;
    logic [1:0]  port_set, port_clr, port_powered, port_good;
    int          num_errors = 0;
    int          checks_done = 0;
    // write word (reserved kept at reset value), expected read-back: flag dropped, count clamped
    rhd_row_s rows [4] = '{'{32'hff00_1fff, 32'hff00_1b0f}, '{32'h0000_0400, 32'h0000_0001},
                           '{32'h0300_0a10, 32'h0300_0a0f}, '{32'h0200_1105, 32'h0200_1105}};
    always #12.5 sys_clk = ~sys_clk;
    rhd_root_hub_desc #(.NPORTS(2)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .rd_valid(rd_valid),
        .rd_data(rd_data), .glob_set(glob_set), .glob_clr(glob_clr),
        .port_set(port_set), .port_clr(port_clr), .port_powered(port_powered),
        .port_good(port_good), .oc_per_port(oc_per_port), .oc_enabled(oc_enabled));
    // ========================================================================
    // tasks: all entered at a falling edge
    // ========================================================================
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        req = '{1'b0, 1'b1, a, d};
        @(negedge sys_clk);
        req = '0;
        @(negedge sys_clk);                              // one idle edge between requests
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        req = '{1'b1, 1'b0, a, 32'h0};
        @(negedge sys_clk);
        req = '0;
        chk("rd_valid", {31'h0, rd_valid}, 32'h1);
        d = rd_data;
        @(negedge sys_clk);                              // one idle edge between requests
    endtask : rd
    // one command pulse {gs, gc, port_set, port_clr}, then settle and look
    task automatic pw(input logic [5:0] c, input logic [1:0] exp);
        {glob_set, glob_clr, port_set, port_clr} = c;
        @(negedge sys_clk);
        {glob_set, glob_clr, port_set, port_clr} = 6'h00;
        repeat (6) @(negedge sys_clk);
        chk("powered", {30'h0, port_powered}, {30'h0, exp});
        chk("good", {30'h0, port_good}, {30'h0, exp});
    endtask : pw
    task automatic stop_test();
        if (num_errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    // ========================================================================
    // main sequence
    // ========================================================================
    initial begin
        sys_rst = 1'b1;
        req = '0;
        {glob_set, glob_clr, port_set, port_clr} = 6'h00;
        repeat (10) @(negedge sys_clk);
        sys_rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        rd(RHD_DESC_A_OFFS, rdat);
        chk("desc_a_rst", rdat, {RHD_POTPG_RST, RHD_RSVD_RST, RHD_NOOC_RST,
            RHD_PSCOPE_RST, 1'b0, RHD_NOPS_RST, RHD_PSCOPE_RST, RHD_NDP_RST});
        foreach (rows[i]) begin
            wr(RHD_DESC_A_OFFS, rows[i].wd);
            rd(RHD_DESC_A_OFFS, rdat);
            chk("desc_a", rdat, rows[i].exp);
            @(negedge sys_clk);
            chk("oc_en", {31'h0, oc_enabled}, {31'h0, ~rows[i].exp[12]});
            chk("oc_pp", {31'h0, oc_per_port}, {31'h0, ~rows[i].exp[12] & rows[i].exp[11]});
        end
        wr(12'h050, 32'hffff_ffff);
        rd(12'h050, rdat);
        chk("unmapped", rdat, 32'h0);
        wr(RHD_DESC_B_OFFS, 32'h0001_0000);
        rd(RHD_DESC_B_OFFS, rdat);
        chk("desc_b", rdat, 32'h0001_0000);
        // ganged first, so the per-port case starts with all ports off
        wr(RHD_DESC_A_OFFS, 32'h0000_0002);
        pw(6'b01_00_00, 2'b00);
        // per-port scope, zero wait, port 0 masked to per-port commands
        wr(RHD_DESC_A_OFFS, 32'h0000_0102);
        pw(6'b10_00_00, 2'b10);
        pw(6'b00_01_00, 2'b11);
        pw(6'b00_00_10, 2'b11);
        pw(6'b01_00_00, 2'b01);
        pw(6'b00_00_01, 2'b00);
        // ganged scope: global only
        wr(RHD_DESC_A_OFFS, 32'h0000_0002);
        pw(6'b10_00_00, 2'b11);
        pw(6'b00_00_11, 2'b11);
        pw(6'b01_00_00, 2'b00);
        // no switching: always powered
        wr(RHD_DESC_A_OFFS, 32'h0000_0202);
        pw(6'b01_00_11, 2'b11);
        sys_rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("powered_rst", {30'h0, port_powered}, 32'h0);
        sys_rst = 1'b0;
        repeat (3) @(negedge sys_clk);
        stop_test();
    end
    // watchdog: about 130 cycles expected, allow well over ten times that
    initial begin
        #(25 * 4000);
        num_errors++;
        stop_test();
    end
endmodule : tb_rhd_root_hub_desc
